// File: rzt_consts.svh
// Constants of the reload timer: register offsets, field positions and reset values
`ifndef RZT_CONSTS_SVH
`define RZT_CONSTS_SVH

`define RZT_ADDR_MODE   8'h00
`define RZT_ADDR_PRE    8'h04
`define RZT_ADDR_PRI    8'h08
`define RZT_ADDR_SEC    8'h0c
`define RZT_ADDR_STAT   8'h10
`define RZT_ADDR_MASK   8'h14

`define RZT_MODE_RUN    0
`define RZT_MODE_WTSEL  1
`define RZT_MODE_SRC_LO 2
`define RZT_MODE_SRC_HI 3
`define RZT_STAT_IRQ    0

`define RZT_RST_RELOAD  8'hff
`define RZT_RST_SRC     2'h0
`define RZT_F8_LAST     3'h7

`endif

// File: rzt_pkg.sv
// Types shared by the reload timer modules
`default_nettype none
package rzt_pkg;
    typedef enum logic [1:0] {
        RZT_SRC_F1  = 2'h0,
        RZT_SRC_F2  = 2'h1,
        RZT_SRC_F8  = 2'h2,
        RZT_SRC_NBR = 2'h3
    } rzt_src_t;

    typedef enum logic [1:0] {
        RZT_ST_IDLE     = 2'h0,
        RZT_ST_WAIT_RLD = 2'h1,
        RZT_ST_WAIT_CNT = 2'h3
    } rzt_wr_state_t;
endpackage : rzt_pkg
`default_nettype wire

// File: rzt_cnt_if.sv
// Control and status bundle between the timer core and one reloadable down counter
`default_nettype none
interface rzt_cnt_if;
    logic       tick;
    logic       load;
    logic [7:0] load_val;
    logic [7:0] reload;
    logic [7:0] count;
    logic       underflow;

    modport cnt (input tick, input load, input load_val, input reload,
                 output count, output underflow);
    modport ctl (output tick, output load, output load_val, output reload,
                 input count, input underflow);
endinterface : rzt_cnt_if
`default_nettype wire

// File: rzt_src_sel.sv
// Count source selection for the reload timer prescaler
`default_nettype none
`include "rzt_consts.svh"
module rzt_src_sel
    import rzt_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire rzt_src_t   src_sel,
    input  wire logic       neighbour_underflow,
    output logic            src_pulse
);
    logic [2:0] div_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    end

    always_comb
    begin
        unique case (src_sel)
            RZT_SRC_F1:  src_pulse = 1'b1;
            RZT_SRC_F2:  src_pulse = div_reg[0];
            RZT_SRC_F8:  src_pulse = (div_reg == `RZT_F8_LAST);
            RZT_SRC_NBR: src_pulse = neighbour_underflow;
        endcase
    end

    property f8_rate_p;
        @(posedge pclk) disable iff (!presetn)
        (src_sel == RZT_SRC_F8 && src_pulse)
        |=> ((src_sel != RZT_SRC_F8 || !src_pulse) [*7])
        ##1 (src_sel != RZT_SRC_F8 || src_pulse);
    endproperty
    f8_rate_a: assert property (f8_rate_p) else $error("f8 source pulse spacing wrong");
endmodule : rzt_src_sel
`default_nettype wire

// File: rzt_down_cnt.sv
// Eight-bit reloadable down counter used for both prescaler and timer
`default_nettype none
`include "rzt_consts.svh"
module rzt_down_cnt
(
    input  wire logic pclk,
    input  wire logic presetn,
    rzt_cnt_if.cnt    c
);
    logic [7:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= `RZT_RST_RELOAD;
        else if (c.load)
            cnt_reg <= c.load_val;
        else if (c.tick)
            cnt_reg <= (cnt_reg == 8'h00) ? c.reload : cnt_reg - 8'h01;
    end

    assign c.count     = cnt_reg;
    assign c.underflow = c.tick && !c.load && (cnt_reg == 8'h00);

    uf_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        c.underflow |=> cnt_reg == $past(c.reload)) else $error("no reload after underflow");
endmodule : rzt_down_cnt
`default_nettype wire

// File: rzt_top.sv
// Reload timer in timer mode with prescaler, APB registers and interrupt
//
// Added by the designer: the register addresses and register access over APB.
`default_nettype none
`include "rzt_consts.svh"
module rzt_top
    import rzt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        neighbour_underflow,
    output logic             timer_underflow,
    output logic             irq
);
    // Register state
    logic          run_control_bit_reg;
    logic          write_target_select_reg;
    rzt_src_t      src_sel_reg;
    logic [7:0]    prescaler_value_reg;
    logic [7:0]    primary_reload_value_reg;
    logic [7:0]    secondary_reload_value_reg;
    logic          interrupt_request_flag_reg;
    logic          irq_mask_reg;
    logic [31:0]   prdata_reg;
    logic          pslverr_reg;

    // Deferred write sequence
    rzt_wr_state_t wr_state_reg;
    rzt_wr_state_t wr_state_next;
    logic          pend_pre_reg;
    logic          pend_pri_reg;
    logic [7:0]    pend_pre_data_reg;
    logic [7:0]    pend_pri_data_reg;

    // Decoded strobes
    logic          wr_en;
    logic          rd_setup;
    logic          wr_mode;
    logic          wr_pre;
    logic          wr_pri;
    logic          wr_sec;
    logic          wr_stat;
    logic          wr_mask;
    logic          wr_deferred;
    logic          wr_direct;
    logic          wr_reload_only;
    logic          src_pulse;
    logic          seq_adv;
    logic          flag_set;

    rzt_cnt_if pre_if ();
    rzt_cnt_if tmr_if ();

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `RZT_ADDR_MODE) || (a == `RZT_ADDR_PRE) || (a == `RZT_ADDR_PRI) ||
               (a == `RZT_ADDR_SEC) || (a == `RZT_ADDR_STAT) || (a == `RZT_ADDR_MASK);
    endfunction : is_mapped

    // APB decode; the slave never inserts wait states
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite && is_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_mode  = wr_en && (paddr == `RZT_ADDR_MODE);
    assign wr_pre   = wr_en && (paddr == `RZT_ADDR_PRE);
    assign wr_pri   = wr_en && (paddr == `RZT_ADDR_PRI);
    assign wr_sec   = wr_en && (paddr == `RZT_ADDR_SEC);
    assign wr_stat  = wr_en && (paddr == `RZT_ADDR_STAT);
    assign wr_mask  = wr_en && (paddr == `RZT_ADDR_MASK);

    // Classify a counter write by run state and write target
    assign wr_direct      = (wr_pre || wr_pri) && !run_control_bit_reg;
    assign wr_deferred    = (wr_pre || wr_pri) && run_control_bit_reg
                            && !write_target_select_reg;
    assign wr_reload_only = run_control_bit_reg && write_target_select_reg;

    // Deferred sequence steps on source pulses; while stopped it steps on every clock
    assign seq_adv = src_pulse || !run_control_bit_reg;

    rzt_src_sel u_src
    (
        .pclk                (pclk),
        .presetn             (presetn),
        .src_sel             (src_sel_reg),
        .neighbour_underflow (neighbour_underflow),
        .src_pulse           (src_pulse)
    );

    rzt_down_cnt u_pre
    (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (pre_if.cnt)
    );

    rzt_down_cnt u_tmr
    (
        .pclk    (pclk),
        .presetn (presetn),
        .c       (tmr_if.cnt)
    );

    // Prescaler counts source pulses, timer counts prescaler underflows
    assign pre_if.tick     = src_pulse && run_control_bit_reg
                             && (wr_state_reg == RZT_ST_IDLE);
    assign tmr_if.tick     = pre_if.underflow;
    assign pre_if.reload   = prescaler_value_reg;
    assign tmr_if.reload   = primary_reload_value_reg;
    assign pre_if.load     = (wr_pre && wr_direct)
                             || (wr_state_reg == RZT_ST_WAIT_CNT && seq_adv && pend_pre_reg);
    assign tmr_if.load     = (wr_pri && wr_direct)
                             || (wr_state_reg == RZT_ST_WAIT_CNT && seq_adv && pend_pri_reg);
    assign pre_if.load_val = wr_direct ? pwdata[7:0] : prescaler_value_reg;
    assign tmr_if.load_val = wr_direct ? pwdata[7:0] : primary_reload_value_reg;
    assign timer_underflow = tmr_if.underflow;

    // Mode register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_control_bit_reg     <= 1'b0;
            write_target_select_reg <= 1'b0;
            src_sel_reg             <= rzt_src_t'(`RZT_RST_SRC);
        end
        else if (wr_mode)
        begin
            run_control_bit_reg     <= pwdata[`RZT_MODE_RUN];
            write_target_select_reg <= pwdata[`RZT_MODE_WTSEL];
            src_sel_reg             <= rzt_src_t'(pwdata[`RZT_MODE_SRC_HI:`RZT_MODE_SRC_LO]);
        end
    end

    // Prescaler reload register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prescaler_value_reg <= `RZT_RST_RELOAD;
        else if (wr_pre && (wr_direct || wr_reload_only))
            prescaler_value_reg <= pwdata[7:0];
        else if (wr_state_reg == RZT_ST_WAIT_RLD && seq_adv && pend_pre_reg)
            prescaler_value_reg <= pend_pre_data_reg;
    end

    // Primary reload register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            primary_reload_value_reg <= `RZT_RST_RELOAD;
        else if (wr_pri && (wr_direct || wr_reload_only))
            primary_reload_value_reg <= pwdata[7:0];
        else if (wr_state_reg == RZT_ST_WAIT_RLD && seq_adv && pend_pri_reg)
            primary_reload_value_reg <= pend_pri_data_reg;
    end

    // Secondary reload is only storage in this mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            secondary_reload_value_reg <= `RZT_RST_RELOAD;
        else if (wr_sec)
            secondary_reload_value_reg <= pwdata[7:0];
    end

    // Pending write data and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_pre_reg      <= 1'b0;
            pend_pri_reg      <= 1'b0;
            pend_pre_data_reg <= 8'h00;
            pend_pri_data_reg <= 8'h00;
        end
        else if (wr_deferred)
        begin
            if (wr_pre)
            begin
                pend_pre_reg      <= 1'b1;
                pend_pre_data_reg <= pwdata[7:0];
            end
            if (wr_pri)
            begin
                pend_pri_reg      <= 1'b1;
                pend_pri_data_reg <= pwdata[7:0];
            end
        end
        else if (wr_state_next == RZT_ST_IDLE)
        begin
            pend_pre_reg <= 1'b0;
            pend_pri_reg <= 1'b0;
        end
    end

    // Deferred write sequence: reload at first pulse, counter at second
    always_comb
    begin
        wr_state_next = wr_state_reg;
        unique case (wr_state_reg)
            RZT_ST_IDLE:
                if (wr_deferred)
                    wr_state_next = RZT_ST_WAIT_RLD;
            RZT_ST_WAIT_RLD:
                if (wr_deferred)
                    wr_state_next = RZT_ST_WAIT_RLD;
                else if (seq_adv)
                    wr_state_next = RZT_ST_WAIT_CNT;
            RZT_ST_WAIT_CNT:
                if (wr_deferred)
                    wr_state_next = RZT_ST_WAIT_RLD;
                else if (seq_adv)
                    wr_state_next = RZT_ST_IDLE;
            default:
                wr_state_next = RZT_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_state_reg <= RZT_ST_IDLE;
        else
            wr_state_reg <= wr_state_next;
    end

    // Interrupt flag: set wins over a write-one clear
    assign flag_set = tmr_if.underflow || wr_deferred;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interrupt_request_flag_reg <= 1'b0;
        else if (flag_set)
            interrupt_request_flag_reg <= 1'b1;
        else if (wr_stat && pwdata[`RZT_STAT_IRQ])
            interrupt_request_flag_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= 1'b0;
        else if (wr_mask)
            irq_mask_reg <= pwdata[`RZT_STAT_IRQ];
    end

    assign irq = interrupt_request_flag_reg && irq_mask_reg;

    // Read data captured in the setup phase, live counts for the counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_reg <= !is_mapped(paddr);
            prdata_reg  <= 32'h0000_0000;
            if (rd_setup)
            begin
                unique case (paddr)
                    `RZT_ADDR_MODE:
                        prdata_reg <= {28'h0000000, src_sel_reg, write_target_select_reg,
                                       run_control_bit_reg};
                    `RZT_ADDR_PRE:  prdata_reg <= {24'h000000, pre_if.count};
                    `RZT_ADDR_PRI:  prdata_reg <= {24'h000000, tmr_if.count};
                    `RZT_ADDR_SEC:  prdata_reg <= {24'h000000, secondary_reload_value_reg};
                    `RZT_ADDR_STAT: prdata_reg <= {31'h0, interrupt_request_flag_reg};
                    `RZT_ADDR_MASK: prdata_reg <= {31'h0, irq_mask_reg};
                    default:        prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;

    // Checks
    run_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_mode && pwdata[`RZT_MODE_RUN]) |=> run_control_bit_reg
        ) else $error("run bit not set by write");

    stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_control_bit_reg && !tmr_if.load && !pre_if.load)
        |=> $stable(tmr_if.count) && $stable(pre_if.count)
        ) else $error("counter moved while stopped");

    uf_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        tmr_if.underflow |=> interrupt_request_flag_reg
        ) else $error("underflow did not raise flag");

    wr_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_deferred |=> interrupt_request_flag_reg && wr_state_reg == RZT_ST_WAIT_RLD
        ) else $error("deferred write missed flag or sequence");

    stop_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_pri && wr_direct) |=> tmr_if.count == $past(pwdata[7:0])
        && primary_reload_value_reg == $past(pwdata[7:0])
        ) else $error("stopped write not in reload and counter");

    reload_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_pri && wr_reload_only && !tmr_if.tick)
        |=> primary_reload_value_reg == $past(pwdata[7:0]) && $stable(tmr_if.count)
        ) else $error("reload-only write touched counter");

    seq_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_state_reg == RZT_ST_WAIT_CNT && seq_adv && !wr_deferred && pend_pri_reg)
        |=> wr_state_reg == RZT_ST_IDLE && tmr_if.count == primary_reload_value_reg
        ) else $error("deferred write not transferred at second pulse");

    pre_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        pre_if.underflow |-> tmr_if.tick ##1 pre_if.count == prescaler_value_reg
        ) else $error("prescaler did not reload");

    read_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_setup && paddr == `RZT_ADDR_PRI) |=> prdata[7:0] == $past(tmr_if.count)
        ) else $error("read did not return live count");

    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!irq_mask_reg) |-> !irq
        ) else $error("masked flag reached irq");

    irq_path_a: assert property (@(posedge pclk) disable iff (!presetn)
        (tmr_if.underflow && irq_mask_reg && !wr_mask) |=> irq
        ) else $error("unmasked underflow did not raise irq");

    reload_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_state_reg == RZT_ST_WAIT_RLD && seq_adv && !wr_deferred
         && pend_pri_reg && !wr_pri)
        |=> primary_reload_value_reg == $past(pend_pri_data_reg)
        && wr_state_reg == RZT_ST_WAIT_CNT
        ) else $error("deferred write not in reload at first pulse");

    seq_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_state_reg != RZT_ST_IDLE && !pre_if.load && !tmr_if.load)
        |=> $stable(pre_if.count) && $stable(tmr_if.count)
        ) else $error("counting not frozen during deferred write");

    sec_inert_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_sec && wr_state_reg == RZT_ST_IDLE)
        |=> $stable(primary_reload_value_reg)
        ) else $error("secondary write changed primary reload");
endmodule : rzt_top
`default_nettype wire

// File: rzt_top_tb_top.sv
// Self-checking testbench of the reload timer in timer mode
`default_nettype none
`include "rzt_consts.svh"
module rzt_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        nbr_uf;
    logic        timer_underflow;
    logic        irq;
    int          mismatches;
    int          samples_checked;
    int          cyc = 0;
    int          uf_count = 0;
    int          last_uf = 0;
    int          prev_uf = 0;

    rzt_top i_rzt_top (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .pready              (pready),
        .prdata              (prdata),
        .pslverr             (pslverr),
        .neighbour_underflow (nbr_uf),
        .timer_underflow     (timer_underflow),
        .irq                 (irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Underflow monitor: counts pulses and keeps the cycle of the last two
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (timer_underflow === 1'b1)
        begin
            uf_count <= uf_count + 1;
            prev_uf  <= last_uf;
            last_uf  <= cyc;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        chk("pslverr on write", 32'h0, {31'h0, err});
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        logic        err;
        apb(1'b0, a, 32'h0, got, err);
        chk(name, exp, got);
    endtask : rd

    task automatic pulse(input int k);
        repeat (k)
        begin
            @(posedge pclk);
            nbr_uf <= 1'b1;
            @(posedge pclk);
            nbr_uf <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
    endtask : pulse

    task automatic period_chk(input int exp_cyc);
        int base;
        base = uf_count;
        while (uf_count < base + 3)
        begin
            @(posedge pclk);
        end
        chk("underflow period", 32'(exp_cyc), 32'(last_uf - prev_uf));
    endtask : period_chk

    task automatic t_reset;
        logic [31:0] got;
        logic        err;
        rd("mode at reset", `RZT_ADDR_MODE, 32'h0);
        rd("prescaler at reset", `RZT_ADDR_PRE, 32'hff);
        rd("primary at reset", `RZT_ADDR_PRI, 32'hff);
        rd("status at reset", `RZT_ADDR_STAT, 32'h0);
        rd("mask at reset", `RZT_ADDR_MASK, 32'h0);
        apb(1'b1, 8'h20, 32'h1, got, err);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h20, 32'h0, got, err);
        chk("unmapped read data", 32'h0, got);
        chk("unmapped read error", 32'h1, {31'h0, err});
    endtask : t_reset

    task automatic t_periods;
        wr(`RZT_ADDR_PRE, 32'h1);
        wr(`RZT_ADDR_PRI, 32'h2);
        wr(`RZT_ADDR_SEC, 32'h10);
        rd("prescaler stopped write", `RZT_ADDR_PRE, 32'h1);
        rd("primary stopped write", `RZT_ADDR_PRI, 32'h2);
        wr(`RZT_ADDR_MODE, 32'h1);
        period_chk(6);
        wr(`RZT_ADDR_MODE, 32'h5);
        period_chk(12);
        wr(`RZT_ADDR_MODE, 32'h9);
        period_chk(48);
        wr(`RZT_ADDR_MODE, 32'h0);
    endtask : t_periods

    task automatic t_irq;
        rd("flag after underflows", `RZT_ADDR_STAT, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`RZT_ADDR_MASK, 32'h1);
        // Mask lands at the access edge; look once it has settled
        @(negedge pclk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`RZT_ADDR_STAT, 32'h1);
        rd("flag cleared", `RZT_ADDR_STAT, 32'h0);
        chk("irq after clear", 32'h0, {31'h0, irq});
    endtask : t_irq

    task automatic t_neighbour;
        int base;
        wr(`RZT_ADDR_PRE, 32'h1);
        wr(`RZT_ADDR_PRI, 32'h2);
        wr(`RZT_ADDR_MODE, 32'hd);
        pulse(3);
        rd("prescaler count", `RZT_ADDR_PRE, 32'h0);
        rd("primary count", `RZT_ADDR_PRI, 32'h1);
        wr(`RZT_ADDR_MODE, 32'hc);
        pulse(3);
        rd("primary held", `RZT_ADDR_PRI, 32'h1);
        rd("prescaler held", `RZT_ADDR_PRE, 32'h0);
        wr(`RZT_ADDR_MODE, 32'hd);
        wr(`RZT_ADDR_MASK, 32'h0);
        wr(`RZT_ADDR_PRI, 32'h5);
        rd("flag on running write", `RZT_ADDR_STAT, 32'h1);
        chk("irq kept off", 32'h0, {31'h0, irq});
        pulse(1);
        rd("counter before copy", `RZT_ADDR_PRI, 32'h1);
        pulse(1);
        rd("counter after copy", `RZT_ADDR_PRI, 32'h5);
        pulse(1);
        rd("counting resumed", `RZT_ADDR_PRI, 32'h4);
        wr(`RZT_ADDR_STAT, 32'h1);
        wr(`RZT_ADDR_MODE, 32'hf);
        wr(`RZT_ADDR_PRI, 32'h2);
        rd("no flag with target one", `RZT_ADDR_STAT, 32'h0);
        rd("counter untouched", `RZT_ADDR_PRI, 32'h4);
        wr(`RZT_ADDR_MASK, 32'h1);
        base = uf_count;
        // Timer at 4 with prescaler reload 1: five ticks of two pulses each
        pulse(10);
        chk("underflow count", 32'h1, 32'(uf_count - base));
        chk("irq on underflow", 32'h1, {31'h0, irq});
        rd("new reload taken", `RZT_ADDR_PRI, 32'h2);
        pulse(6);
        chk("second underflow", 32'h2, 32'(uf_count - base));
    endtask : t_neighbour

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        nbr_uf = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_periods();
        t_irq();
        t_neighbour();
        test_done();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (50000) @(posedge pclk);
        mismatches++;
        test_done();
    end
endmodule : rzt_top_tb_top
`default_nettype wire
